// File: hw/pmbus_command_decoder.sv
// command decoder: classifies pmbus codes, drives action strobes and nonvolatile ops
//
// Summary of operation
// R1 - status never reports a busy indication
// R2 - host leaves bus-free gap between transactions
// R3 - host waits 100 ms after store
// R4 - host waits 100 ms after restore
// R5 - standard smbus protocols, host tolerates stretching
// R6 - answer commands per pmbus transport rules
// R7 - act on every implemented command code
// R8 - unimplemented codes are treated as absent
// R9 - tap calc, sense offset only without compensation
// R10 - auto tuning codes only with compensation
// R11 - store user copies working settings out
// R12 - default area protected, restore default reloads
// R13 - bad code flags cml fault, settings unchanged
`timescale 1ns/10ps
`include "pmbus_command_decoder_defines.svh"

module pmbus_command_decoder #(
   parameter bit ADAPTIVE_LOOP_COMPENSATION = 1'b0,
   parameter int NV_DELAY_CYCLES = `NV_DELAY_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire pmbus_command_decoder_pkg::command_type i_command,
   input wire logic i_clear_cml,
   input wire logic i_nv_done,
   output logic o_accept,
   output pmbus_command_decoder_pkg::decode_type o_action,
   output logic [2:0] o_nv_op,
   output logic o_nv_start,
   output logic o_default_area_write_enable,
   output logic o_cml_invalid,
   output logic [7:0] o_status_cml,
   output logic o_status_busy,
   output logic o_stretch
);
   import pmbus_command_decoder_pkg::*;

   // elaboration check: the settle window needs at least one cycle to count
   if (NV_DELAY_CYCLES < 1) begin : gen_bad_delay
      $error("NV_DELAY_CYCLES must be at least one");
   end

   // implemented code table, variant commands gated by the compensation option
   function automatic logic is_implemented(input logic [7:0] c);
      logic r;
      r = 1'b0;
      case (c)
         8'h01, 8'h02, 8'h03, 8'h11, 8'h12, 8'h15, 8'h16: r = 1'b1; // R7
         8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28: r = 1'b1; // R7
         8'h32, 8'h33, 8'h37, 8'h38, 8'h39: r = 1'b1; // R7
         8'h40, 8'h41, 8'h44, 8'h45, 8'h46, 8'h4b, 8'h4f: r = 1'b1; // R7
         8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57: r = 1'b1; // R7
         8'h58, 8'h59, 8'h5a, 8'h5e, 8'h60, 8'h61, 8'h64, 8'h65: r = 1'b1; // R7
         8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80: r = 1'b1; // R7
         8'h88, 8'h8b, 8'h8c, 8'h8d, 8'h94, 8'h95: r = 1'b1; // R7
         8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'hb0, 8'hbf: r = 1'b1; // R7
         8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd7, 8'hd8: r = 1'b1; // R7
         8'hdc, 8'hdd, 8'hde, 8'he0, 8'he1, 8'he2, 8'he4, 8'he5, 8'he6: r = 1'b1; // R7
         8'he7, 8'he8, 8'he9, 8'hea, 8'hf0, 8'hf3, 8'hfa, 8'hfb, 8'hfc, 8'hfd: r = 1'b1; // R7
         `CMD_COMP_TAP_CALC, `CMD_CURRENT_SENSE_OFFSET: r = !ADAPTIVE_LOOP_COMPENSATION; // R9
         `CMD_AUTO_TUNE_CONTROL, `CMD_AUTO_TUNE_CONFIG: r = ADAPTIVE_LOOP_COMPENSATION; // R10
         default: r = 1'b0; // R8
      endcase
      return r;
   endfunction

   decoder_state_type state, next_state;
   logic [31:0] wait_count, next_wait_count;
   decode_type action, next_action;
   logic [2:0] nv_op, next_nv_op;
   logic nv_start, next_nv_start;
   logic cml_invalid, next_cml_invalid;
   logic hit;

   assign hit = i_command.valid && is_implemented(i_command.code);

   // next-state logic for decode, nonvolatile sequencing and fault flag
   always_comb begin
      next_state = state;
      next_wait_count = wait_count;
      next_action = '0;
      next_nv_op = nv_op;
      next_nv_start = 1'b0;
      next_cml_invalid = cml_invalid;
      if (i_clear_cml) begin
         next_cml_invalid = 1'b0;
      end
      case (state)
         ST_IDLE: begin
            if (i_command.valid && !hit) begin
               next_cml_invalid = 1'b1; // R13
               next_state = ST_FAULT;
            end else if (hit) begin
               next_action.hit = 1'b1; // R6
               next_action.code = i_command.code; // R7
               next_wait_count = 32'(NV_DELAY_CYCLES);
               case (i_command.code)
                  `CMD_STORE_USER_ALL: begin
                     next_nv_op = NV_STORE_USER; // R11
                     next_nv_start = 1'b1;
                     next_state = ST_STORE;
                  end
                  `CMD_STORE_DEFAULT_ALL: begin
                     next_nv_op = NV_STORE_DEFAULT;
                     next_nv_start = 1'b1;
                     next_state = ST_STORE;
                  end
                  `CMD_RESTORE_USER_ALL: begin
                     next_nv_op = NV_RESTORE_USER;
                     next_nv_start = 1'b1;
                     next_state = ST_RESTORE;
                  end
                  `CMD_RESTORE_DEFAULT_ALL: begin
                     next_nv_op = NV_RESTORE_DEFAULT; // R12
                     next_nv_start = 1'b1;
                     next_state = ST_RESTORE;
                  end
                  default: next_state = ST_IDLE;
               endcase
            end
         end
         ST_STORE, ST_RESTORE: begin
            // hold off until memory done and the settle window has run out
            if (wait_count != 32'h0) begin
               next_wait_count = wait_count - 32'h1;
            end
            if (i_nv_done && wait_count <= 32'h1) begin
               next_nv_op = NV_NONE;
               next_state = ST_IDLE;
            end
         end
         ST_FAULT: next_state = ST_IDLE; // settings untouched, one-cycle recovery
         default: next_state = ST_IDLE;
      endcase
      if (state == ST_IDLE && i_command.valid && !hit) begin
         next_cml_invalid = 1'b1; // set wins over clear
      end
   end

   // state registers
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state <= ST_IDLE;
         wait_count <= 32'h0;
         action <= '0;
         nv_op <= NV_NONE;
         nv_start <= 1'b0;
         cml_invalid <= 1'b0;
      end else begin
         state <= next_state;
         wait_count <= next_wait_count;
         action <= next_action;
         nv_op <= next_nv_op;
         nv_start <= next_nv_start;
         cml_invalid <= next_cml_invalid;
      end
   end

   // outputs; busy is never reported, long operations stretch the clock instead
   assign o_accept = (state == ST_IDLE);
   assign o_stretch = (state == ST_STORE) || (state == ST_RESTORE); // R5
   assign o_action = action;
   assign o_nv_op = nv_op;
   assign o_nv_start = nv_start;
   assign o_default_area_write_enable = 1'b0; // R12
   assign o_status_busy = 1'b0; // R1
   assign o_cml_invalid = cml_invalid;

   // status byte: only the invalid-command bit carries a flag, the rest read zero
   for (genvar b = 0; b < 8; b++) begin : gen_status_cml
      if (b == `CML_INVALID_CMD_BIT) begin : gen_flag
         assign o_status_cml[b] = cml_invalid; // R13
      end else begin : gen_zero
         assign o_status_cml[b] = 1'b0;
      end
   end

   AST_NO_BUSY: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R1
      !o_status_busy) else $error("busy reported");
   AST_OPERATION_HIT: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R7
      (o_accept && i_command.valid && i_command.code == `CMD_OPERATION)
      |=> (o_action.hit && o_action.code == `CMD_OPERATION))
      else $error("operation not decoded");
   AST_READ_VOUT_HIT: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R7
      (o_accept && i_command.valid && i_command.code == `CMD_READ_VOUT)
      |=> o_action.hit) else $error("read vout not decoded");
   AST_PAGE_ABSENT: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R8
      (o_accept && i_command.valid && i_command.code == 8'h00)
      |=> (!o_action.hit && o_cml_invalid)) else $error("page accepted");
   AST_VARIANT_TAP: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R9
      (o_accept && i_command.valid && i_command.code == `CMD_COMP_TAP_CALC)
      |=> (o_action.hit == !ADAPTIVE_LOOP_COMPENSATION)) else $error("tap calc variant");
   AST_VARIANT_TUNE: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R10
      (o_accept && i_command.valid && i_command.code == `CMD_AUTO_TUNE_CONTROL)
      |=> (o_action.hit == ADAPTIVE_LOOP_COMPENSATION)) else $error("tune variant");
   AST_STORE_USER: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R11
      (o_accept && i_command.valid && i_command.code == `CMD_STORE_USER_ALL)
      |=> (o_nv_start && o_nv_op == NV_STORE_USER && o_stretch))
      else $error("store user not started");
   AST_DEFAULT_PROTECT: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R12
      (o_accept && i_command.valid && i_command.code == `CMD_RESTORE_DEFAULT_ALL)
      |=> (o_nv_op == NV_RESTORE_DEFAULT && !o_default_area_write_enable))
      else $error("restore default wrong");
   AST_BAD_NO_ACTION: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R13
      (o_accept && i_command.valid && !hit) |=> (!o_action.hit && !o_nv_start && o_cml_invalid))
      else $error("bad code acted on");
   AST_STATUS_MIRROR: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R13
      o_status_cml == {o_cml_invalid, 7'h00}) else $error("cml status byte wrong");
   AST_CLEAR_FLAG: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R13
      (i_clear_cml && !(o_accept && i_command.valid && !hit)) |=> !o_cml_invalid)
      else $error("cml flag not cleared");
   AST_REFUSED_IDLE: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R5
      (!o_accept && i_command.valid) |=> (!o_action.hit && !o_nv_start))
      else $error("command taken while stretching");
   AST_OP_HOLDS: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R5
      (o_stretch && !i_nv_done) |=> (o_stretch && o_nv_op != 3'h0))
      else $error("op ended before memory done");
   AST_NO_DEFAULT_WRITE: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R12
      o_stretch |-> !o_default_area_write_enable) else $error("default area writable");
   AST_RESTORE_USER: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R6
      (o_accept && i_command.valid && i_command.code == `CMD_RESTORE_USER_ALL)
      |=> (o_nv_start && o_nv_op == NV_RESTORE_USER && o_stretch))
      else $error("restore user not started");
endmodule // pmbus_command_decoder

// File: inc/pmbus_command_decoder_defines.svh
// command codes, status bit positions and timing counts for the command decoder
`ifndef PMBUS_COMMAND_DECODER_DEFINES_SVH
`define PMBUS_COMMAND_DECODER_DEFINES_SVH
`define CMD_OPERATION 8'h01
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_STORE_DEFAULT_ALL 8'h11
`define CMD_RESTORE_DEFAULT_ALL 8'h12
`define CMD_STORE_USER_ALL 8'h15
`define CMD_RESTORE_USER_ALL 8'h16
`define CMD_STATUS_WORD 8'h79
`define CMD_READ_VOUT 8'h8b
`define CMD_COMP_TAP_CALC 8'hf2
`define CMD_CURRENT_SENSE_OFFSET 8'hbe
`define CMD_AUTO_TUNE_CONTROL 8'hbd
`define CMD_AUTO_TUNE_CONFIG 8'hbc
`define CML_INVALID_CMD_BIT 7
`define STATUS_BUSY_BIT 7
`define NV_DELAY_MS 100
`define CLOCK_MHZ 100
`define NV_DELAY_CYCLES (`NV_DELAY_MS * 1000 * `CLOCK_MHZ)
`endif

// File: inc/pmbus_command_decoder_pkg.sv
// types shared by the command decoder
package pmbus_command_decoder_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_STORE = 4'b0010,
      ST_RESTORE = 4'b0100,
      ST_FAULT = 4'b1000
   } decoder_state_type;

   typedef enum logic [2:0] {
      NV_NONE = 3'h0,
      NV_STORE_USER = 3'h1,
      NV_STORE_DEFAULT = 3'h2,
      NV_RESTORE_USER = 3'h3,
      NV_RESTORE_DEFAULT = 3'h4
   } nv_op_type;

   typedef struct packed {
      logic valid;
      logic [7:0] code;
      logic is_write;
   } command_type;

   typedef struct packed {
      logic hit;
      logic [7:0] code;
   } decode_type;
endpackage

// File: tb/nv_store_model.sv
// behavioural nonvolatile settings store that answers the decoder's start pulses
`timescale 1ns/10ps
module nv_store_model (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_nv_start,
   input wire logic [2:0] i_nv_op,
   input wire logic i_default_area_write_enable,
   input wire logic i_slow,
   output logic o_nv_done,
   output logic o_default_written
);
   int wait_count;
   // a copy or reload ends after a short or long wait; done holds until the op ends
   always @(posedge i_clock) begin
      if (i_sys_rst || i_nv_op == 3'h0) begin
         wait_count <= 0;
         o_nv_done <= 1'b0;
      end else if (i_nv_start) begin
         wait_count <= i_slow ? 20 : 2;
      end else if (wait_count > 1) begin
         wait_count <= wait_count - 1;
      end else begin
         o_nv_done <= 1'b1;
      end
   end
   // the default area is written only while its write enable is up
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_default_written <= 1'b0;
      end else if (i_nv_op == 3'h2 && i_default_area_write_enable) begin
         o_default_written <= 1'b1;
      end
   end
endmodule // nv_store_model

// File: tb/pmbus_command_decoder_test.sv
// self-checking bench for the command decoder with both compensation variants
`timescale 1ns/10ps
module pmbus_command_decoder_test;
   import pmbus_command_decoder_pkg::*;
   localparam int NV_CYCLES = 8;
   logic i_clock, i_sys_rst, i_clear_cml, i_nv_done, slow, o_accept, o_nv_start, o_stretch;
   logic o_default_area_write_enable, o_cml_invalid, o_status_busy, alc_cml, written;
   command_type i_command;
   decode_type o_action, alc_action;
   logic [2:0] o_nv_op;
   logic [7:0] o_status_cml;
   int errors = 0, n_tests = 0, cycles = 0, stall;
   logic [7:0] impl_codes [8] = '{8'h01, 8'h03, 8'h79, 8'h8b, 8'h20, 8'h5e, 8'h95, 8'hf0};
   logic [7:0] bad_codes [5] = '{8'h00, 8'h10, 8'h35, 8'h36, 8'h04};
   logic [7:0] var_codes [4] = '{8'hf2, 8'hbe, 8'hbd, 8'hbc};
   logic [7:0] nv_codes [4] = '{8'h15, 8'h11, 8'h16, 8'h12};
   pmbus_command_decoder #(.NV_DELAY_CYCLES(NV_CYCLES)) dut (.i_clock(i_clock),
      .i_sys_rst(i_sys_rst), .i_command(i_command), .i_clear_cml(i_clear_cml),
      .i_nv_done(i_nv_done), .o_accept(o_accept), .o_action(o_action), .o_nv_op(o_nv_op),
      .o_nv_start(o_nv_start), .o_default_area_write_enable(o_default_area_write_enable),
      .o_cml_invalid(o_cml_invalid), .o_status_cml(o_status_cml),
      .o_status_busy(o_status_busy), .o_stretch(o_stretch));
   pmbus_command_decoder #(.ADAPTIVE_LOOP_COMPENSATION(1'b1), .NV_DELAY_CYCLES(NV_CYCLES))
      dut_alc (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_command(i_command),
      .i_clear_cml(i_clear_cml), .i_nv_done(i_nv_done), .o_accept(), .o_action(alc_action),
      .o_nv_op(), .o_nv_start(), .o_default_area_write_enable(), .o_cml_invalid(alc_cml),
      .o_status_cml(), .o_status_busy(), .o_stretch());
   nv_store_model store (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_nv_start(o_nv_start),
      .i_nv_op(o_nv_op), .i_default_area_write_enable(o_default_area_write_enable),
      .i_slow(slow), .o_nv_done(i_nv_done), .o_default_written(written));
   // free-running clock
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one idle cycle as bus-free gap, then a one-cycle command pulse
   task automatic send(input logic [7:0] code);
      @(posedge i_clock);
      #1 i_command.valid = 1'b1;
      i_command.code = code;
      @(posedge i_clock);
      #1 i_command.valid = 1'b0;
   endtask
   task automatic clear_flag;
      @(posedge i_clock);
      #1 i_clear_cml = 1'b1;
      @(posedge i_clock);
      #1 i_clear_cml = 1'b0;
   endtask
   // hang guard
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      i_sys_rst = 1'b1;
      i_command = '0;
      i_clear_cml = 1'b0;
      slow = 1'b0;
      repeat (6) @(posedge i_clock);
      #1 i_sys_rst = 1'b0;
      check("accept", o_accept, 1'b1);
      check("busy", o_status_busy, 1'b0);
      check("wr_enable", o_default_area_write_enable, 1'b0);
      foreach (impl_codes[i]) begin
         send(impl_codes[i]);
         check("action", o_action, {1'b1, impl_codes[i]});
         check("cml_ok", o_cml_invalid, 1'b0);
      end
      foreach (var_codes[i]) begin
         send(var_codes[i]);
         check("plain_hit", o_action.hit, i < 2);
         check("alc_hit", alc_action.hit, i >= 2);
         check("alc_cml", alc_cml, i < 2);
         clear_flag();
      end
      foreach (bad_codes[i]) begin
         send(bad_codes[i]);
         check("bad_hit", o_action.hit, 1'b0);
         check("status_cml", o_status_cml, 8'h80);
         check("lost_cycle", o_accept, 1'b0);
         clear_flag();
         check("cml_clear", o_status_cml, 8'h00);
      end
      fork // bad code and clear in one cycle: the set wins
         send(8'h10);
         clear_flag();
      join
      check("set_wins", o_cml_invalid, 1'b1);
      clear_flag();
      check("cml_cleared", o_cml_invalid, 1'b0);
      for (int i = 0; i < 4; i++) begin
         slow = i[0];
         send(nv_codes[i]);
         check("nv_start", o_nv_start, 1'b1);
         check("nv_op", o_nv_op, 16'(i + 1));
         check("stretch", o_stretch, 1'b1);
         check("busy_op", o_status_busy, 1'b0);
         send(8'h01);
         check("refused", o_action.hit, 1'b0);
         stall = 3;
         while (o_accept !== 1'b1 && stall < 200) begin
            @(posedge i_clock);
            #1 stall++;
         end
         check("nv_wait", stall >= NV_CYCLES + 1 && stall <= 24, 1'b1);
         check("nv_end", {o_nv_op, o_stretch}, 4'h0);
         check("default_kept", written, 1'b0);
      end
      complete_run();
   end
endmodule // pmbus_command_decoder_test
